// ===== verilog/grac_rotation.sv
// grac_rotation: static rotation angles from one accelerometer sample.
// assumes samples synchronous to sys_clk, one at a time via valid/ready.
`timescale 1ns/100ps
`default_nettype none
module grac_rotation (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic signed [15:0] acc_x,
    input wire logic signed [15:0] acc_y,
    input wire logic signed [15:0] acc_z,
    input wire logic acc_valid,
    output logic acc_ready,
    input wire logic cfg_euler,
    output logic signed [15:0] ang_pitch,
    output logic signed [15:0] ang_roll,
    output logic ang_valid,
    output logic ang_is_euler,
    output logic flag_rollover,
    output logic flag_pitch_lock,
    output logic flag_roll_lock
);
    ////////////////////////////////////////////////////////////////////
    // saturating negate; -(-32768) would wrap back to itself
    function automatic logic signed [15:0] neg16(input logic signed [15:0] a);
        neg16 = (a == grac_pkg::ACC_MIN) ? grac_pkg::ACC_MAX : -a;
    endfunction

    // angle magnitude beyond a quarter turn, 180 included
    function automatic logic over90(input logic signed [15:0] a);
        over90 = (a > grac_pkg::ANG_90) || (a < grac_pkg::ANG_M90);
    endfunction

    grac_pkg::grac_state_t state, next_state;
    logic signed [15:0] gx, next_gx;
    logic signed [15:0] gy, next_gy;
    logic signed [15:0] gz, next_gz;
    logic euler_q, next_euler_q;
    logic launch, next_launch;
    logic signed [15:0] roll_u, next_roll_u;
    logic signed [15:0] pitch_u, next_pitch_u;
    logic signed [grac_pkg::DAT_W-1:0] mag, next_mag;
    logic signed [15:0] next_ang_pitch;
    logic signed [15:0] next_ang_roll;
    logic next_ang_valid;
    logic next_ang_is_euler;
    logic next_flag_rollover;
    logic next_flag_pitch_lock;
    logic next_flag_roll_lock;
    // full product width, 20 + 17 bits, so nothing is cut by the multiply
    logic signed [36:0] mag_prod;
    logic signed [15:0] ngx;
    logic lock_roll;
    logic lock_pitch;

    grac_cordic_if cif ();

    grac_atan2 #(
        .ITER(grac_pkg::CORDIC_ITER)
    ) u_atan2 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cif(cif)
    );

    ////////////////////////////////////////////////////////////////////
    // engine operands per phase
    // sign convention
    assign ngx = neg16(gx);
    assign mag_prod = cif.mag * $signed({1'b0, grac_pkg::INV_GAIN});
    assign lock_roll = (gy == '0) && (gz == '0);
    assign lock_pitch = (gx == '0) && (gz == '0);
    assign acc_ready = (state == grac_pkg::GRAC_IDLE);
    assign cif.start = launch;
    always_comb begin
        case (state)
            grac_pkg::GRAC_ROLL: begin
                cif.x = 20'(gz);
                cif.y = 20'(gy);
            end
            grac_pkg::GRAC_PUNIT: begin
                cif.x = 20'(gz);
                cif.y = 20'(ngx);
            end
            default: begin
                cif.x = mag;
                cif.y = 20'(ngx);
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer: roll, unit pitch, euler pitch, then publish together
    always_comb begin
        next_state = state;
        next_gx = gx;
        next_gy = gy;
        next_gz = gz;
        next_euler_q = euler_q;
        next_launch = 1'b0;
        next_roll_u = roll_u;
        next_pitch_u = pitch_u;
        next_mag = mag;
        next_ang_pitch = ang_pitch;
        next_ang_roll = ang_roll;
        next_ang_valid = 1'b0;
        next_ang_is_euler = ang_is_euler;
        next_flag_rollover = flag_rollover;
        next_flag_pitch_lock = flag_pitch_lock;
        next_flag_roll_lock = flag_roll_lock;
        case (state)
            grac_pkg::GRAC_IDLE: begin
                if (acc_valid) begin
                    next_gx = neg16(acc_x);
                    next_gy = neg16(acc_y);
                    next_gz = neg16(acc_z);
                    next_euler_q = cfg_euler;
                    next_state = grac_pkg::GRAC_ROLL;
                    next_launch = 1'b1;
                end
            end
            grac_pkg::GRAC_ROLL: begin
                if (cif.done) begin
                    next_roll_u = cif.angle;
                    next_mag = mag_prod[34:15];
                    next_state = grac_pkg::GRAC_PUNIT;
                    next_launch = 1'b1;
                end
            end
            grac_pkg::GRAC_PUNIT: begin
                if (cif.done) begin
                    next_pitch_u = cif.angle;
                    next_state = grac_pkg::GRAC_PEUL;
                    next_launch = 1'b1;
                end
            end
            grac_pkg::GRAC_PEUL: begin
                if (cif.done) begin
                    next_state = grac_pkg::GRAC_IDLE;
                    next_ang_valid = 1'b1;
                    next_ang_is_euler = euler_q;
                    // roll lock, value forced to zero
                    next_flag_roll_lock = lock_roll;
                    next_ang_roll = lock_roll ? grac_pkg::ANG_ZERO : roll_u;
                    if (euler_q) begin
                        if (cif.angle > grac_pkg::ANG_90)
                            next_ang_pitch = grac_pkg::ANG_90;
                        else if (cif.angle < grac_pkg::ANG_M90)
                            next_ang_pitch = grac_pkg::ANG_M90;
                        else
                            next_ang_pitch = cif.angle;
                        next_flag_pitch_lock = lock_roll && (gx == '0);
                        next_flag_rollover = over90(roll_u);
                    end else begin
                        next_flag_pitch_lock = lock_pitch;
                        next_ang_pitch = lock_pitch ? grac_pkg::ANG_ZERO
                                                    : pitch_u;
                        next_flag_rollover = over90(pitch_u)
                                             || over90(roll_u);
                    end
                end
            end
            default: next_state = grac_pkg::GRAC_IDLE;
        endcase
    end

    // no yaw output exists; registers only
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= grac_pkg::GRAC_IDLE;
            gx <= '0;
            gy <= '0;
            gz <= '0;
            euler_q <= 1'b0;
            launch <= 1'b0;
            roll_u <= '0;
            pitch_u <= '0;
            mag <= '0;
            ang_pitch <= '0;
            ang_roll <= '0;
            ang_valid <= 1'b0;
            ang_is_euler <= 1'b0;
            flag_rollover <= 1'b0;
            flag_pitch_lock <= 1'b0;
            flag_roll_lock <= 1'b0;
        end else begin
            state <= next_state;
            gx <= next_gx;
            gy <= next_gy;
            gz <= next_gz;
            euler_q <= next_euler_q;
            launch <= next_launch;
            roll_u <= next_roll_u;
            pitch_u <= next_pitch_u;
            mag <= next_mag;
            ang_pitch <= next_ang_pitch;
            ang_roll <= next_ang_roll;
            ang_valid <= next_ang_valid;
            ang_is_euler <= next_ang_is_euler;
            flag_rollover <= next_flag_rollover;
            flag_pitch_lock <= next_flag_pitch_lock;
            flag_roll_lock <= next_flag_roll_lock;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks; gx/gy/gz still hold the sample when ang_valid pulses
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // helper: mode as offered at acceptance, kept apart from the datapath
    logic mode_seen, next_mode_seen;
    always_comb begin
        next_mode_seen = mode_seen;
        if (acc_valid && acc_ready) begin
            next_mode_seen = cfg_euler;
        end
    end

    // helper register for the mode check
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_seen <= 1'b0;
        end else begin
            mode_seen <= next_mode_seen;
        end
    end

    AST_NEG_GRAVITY: assert property (
        (acc_valid && acc_ready) |=> (gx == neg16($past(acc_x)))
        && (gz == neg16($past(acc_z))))
        else $error("gravity is not the negated reading");
    AST_LATENCY: assert property (
        (acc_valid && acc_ready) |-> ##[3:80] ang_valid)
        else $error("no result within 80 cycles");
    AST_UNIT_LEVEL: assert property (
        (ang_valid && !ang_is_euler && gx == 0 && gy == 0 && gz > 0)
        |-> (ang_pitch == 0 && ang_roll == 0))
        else $error("level unit angles not zero");
    AST_EULER_LEVEL: assert property (
        (ang_valid && ang_is_euler && gx == 0 && gy == 0 && gz > 0)
        |-> (ang_pitch == 0 && ang_roll == 0))
        else $error("level euler angles not zero");
    AST_ROLL_LOCK: assert property (
        ang_valid |-> (flag_roll_lock == (gy == 0 && gz == 0)))
        else $error("roll lock flag wrong");
    AST_PITCH_LOCK: assert property (
        (ang_valid && !ang_is_euler)
        |-> (flag_pitch_lock == (gx == 0 && gz == 0)))
        else $error("unit pitch lock flag wrong");
    AST_UNIT_ROLLOVER: assert property (
        (ang_valid && !ang_is_euler && !flag_pitch_lock && !flag_roll_lock)
        |-> (flag_rollover == (over90(ang_pitch) || over90(ang_roll))))
        else $error("unit roll-over flag wrong");
    AST_EULER_ROLLOVER: assert property (
        (ang_valid && ang_is_euler && !flag_roll_lock)
        |-> (flag_rollover == over90(ang_roll)))
        else $error("euler roll-over flag wrong");
    AST_EULER_RANGE: assert property (
        (ang_valid && ang_is_euler) |-> !over90(ang_pitch))
        else $error("euler pitch beyond quarter turn");
    AST_ROLL_SIGN: assert property (
        (ang_valid && gy > 16'sh0100 && gz > 16'sh0100 && gx == 0)
        |-> (ang_roll > 0 && ang_roll < grac_pkg::ANG_90))
        else $error("roll sign wrong");
    AST_MODE_HOLD: assert property (
        ang_valid |-> (ang_is_euler == mode_seen))
        else $error("mode not applied to result");

    COV_UNIT: cover property (ang_valid && !ang_is_euler);
    COV_EULER_OVER: cover property (ang_valid && ang_is_euler
        && flag_rollover);
    COV_ROLL_LOCK: cover property (ang_valid && flag_roll_lock);
endmodule // grac_rotation
`default_nettype wire

// ===== verilog/grac_pkg.sv
// grac_pkg: shared constants and types of the gravity rotation angle block.
// assumes binary angle units: 16-bit signed, full scale +/-180 degrees.
`default_nettype none
package grac_pkg;
    // data width inside the vector engine; inputs are 16-bit signed
    localparam int DAT_W = 20;
    localparam int ANG_W = 16;
    localparam int ACC_W = 16;
    // vector engine iteration count
    localparam int CORDIC_ITER = 14;
    // angle codes: lsb = 180/32768 degree
    localparam logic signed [15:0] ANG_ZERO = 16'sh0000;
    localparam logic signed [15:0] ANG_90 = 16'sh4000;
    localparam logic signed [15:0] ANG_M90 = 16'shc000;
    localparam logic signed [15:0] ANG_180 = 16'sh8000;
    // inverse engine gain, 0.60725 in q1.15
    localparam logic signed [15:0] INV_GAIN = 16'sh4dba;
    localparam int INV_GAIN_SH = 15;
    // most negative and most positive accelerometer codes
    localparam logic signed [15:0] ACC_MIN = 16'sh8000;
    localparam logic signed [15:0] ACC_MAX = 16'sh7fff;
    // sequencer states
    typedef enum logic [3:0] {
        GRAC_IDLE = 4'b0001,
        GRAC_ROLL = 4'b0010,
        GRAC_PUNIT = 4'b0100,
        GRAC_PEUL = 4'b1000
    } grac_state_t;
endpackage
`default_nettype wire

// ===== verilog/grac_cordic_if.sv
// grac_cordic_if: request and answer between the sequencer and the engine.
// assumes both ends share sys_clk; start is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
interface grac_cordic_if;
    logic start;
    logic signed [grac_pkg::DAT_W-1:0] x;
    logic signed [grac_pkg::DAT_W-1:0] y;
    logic done;
    logic signed [grac_pkg::ANG_W-1:0] angle;
    logic signed [grac_pkg::DAT_W-1:0] mag;
    modport eng(input start, input x, input y,
        output done, output angle, output mag);
    modport ctl(output start, output x, output y,
        input done, input angle, input mag);
endinterface
`default_nettype wire

// ===== verilog/grac_atan2.sv
// grac_atan2: iterative vectoring engine, angle = atan2(y, x), mag = k*|v|.
// assumes x and y stand stable in the start cycle; |x|,|y| below 2^17.
`timescale 1ns/100ps
`default_nettype none
module grac_atan2 #(
    parameter int ITER = grac_pkg::CORDIC_ITER
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    grac_cordic_if.eng cif
);
    ////////////////////////////////////////////////////////////////////
    // arctangent of 2^-i in angle codes
    function automatic logic signed [15:0] atan_lut(input logic [3:0] i);
        case (i)
            4'h0: atan_lut = 16'sh2000;
            4'h1: atan_lut = 16'sh12e4;
            4'h2: atan_lut = 16'sh09fb;
            4'h3: atan_lut = 16'sh0511;
            4'h4: atan_lut = 16'sh028b;
            4'h5: atan_lut = 16'sh0146;
            4'h6: atan_lut = 16'sh00a3;
            4'h7: atan_lut = 16'sh0051;
            4'h8: atan_lut = 16'sh0029;
            4'h9: atan_lut = 16'sh0014;
            4'ha: atan_lut = 16'sh000a;
            4'hb: atan_lut = 16'sh0005;
            4'hc: atan_lut = 16'sh0003;
            4'hd: atan_lut = 16'sh0001;
            default: atan_lut = 16'sh0000;
        endcase
    endfunction

    logic signed [grac_pkg::DAT_W-1:0] cx, next_cx;
    logic signed [grac_pkg::DAT_W-1:0] cy, next_cy;
    logic signed [15:0] cz, next_cz;
    logic [3:0] step, next_step;
    logic run, next_run;
    logic hold, next_hold;
    logic done, next_done;

    ////////////////////////////////////////////////////////////////////
    // y == 0 holds the angle exact (0 or 180) so a level unit reads zero
    // exact level zero
    always_comb begin
        next_cx = cx;
        next_cy = cy;
        next_cz = cz;
        next_step = step;
        next_run = run;
        next_hold = hold;
        next_done = 1'b0;
        if (cif.start) begin
            next_run = 1'b1;
            next_step = 4'h0;
            next_hold = (cif.y == '0);
            if (cif.x < 0) begin
                // pre-rotate the left half plane by a quarter turn
                if (cif.y >= 0) begin
                    next_cx = cif.y;
                    next_cy = -cif.x;
                    next_cz = (cif.y == '0) ? grac_pkg::ANG_180
                                            : grac_pkg::ANG_90;
                end else begin
                    next_cx = -cif.y;
                    next_cy = cif.x;
                    next_cz = grac_pkg::ANG_M90;
                end
            end else begin
                next_cx = cif.x;
                next_cy = cif.y;
                next_cz = grac_pkg::ANG_ZERO;
            end
        end else if (run) begin
            if (cy >= 0) begin
                next_cx = cx + (cy >>> step);
                next_cy = cy - (cx >>> step);
                if (!hold) next_cz = cz + atan_lut(step);
            end else begin
                next_cx = cx - (cy >>> step);
                next_cy = cy + (cx >>> step);
                if (!hold) next_cz = cz - atan_lut(step);
            end
            if (step == 4'(ITER - 1)) begin
                next_run = 1'b0;
                next_done = 1'b1;
            end else begin
                next_step = step + 4'h1;
            end
        end
    end

    // state registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cx <= '0;
            cy <= '0;
            cz <= '0;
            step <= 4'h0;
            run <= 1'b0;
            hold <= 1'b0;
            done <= 1'b0;
        end else begin
            cx <= next_cx;
            cy <= next_cy;
            cz <= next_cz;
            step <= next_step;
            run <= next_run;
            hold <= next_hold;
            done <= next_done;
        end
    end

    assign cif.done = done;
    assign cif.angle = cz;
    assign cif.mag = cx;
endmodule // grac_atan2
`default_nettype wire

// ===== sim/grac_acc_src.sv
// grac_acc_src: accelerometer sample source facing the rotation block.
// assumes acc_ready is a level decided by state, stable between edges.
`timescale 1ns/100ps
`default_nettype none
module grac_acc_src (
    input wire logic sys_clk,
    input wire logic acc_ready,
    output logic signed [15:0] acc_x,
    output logic signed [15:0] acc_y,
    output logic signed [15:0] acc_z,
    output logic acc_valid
);
    ////////////////////////////////////////////////////////////////////////
    // idle lines start low; nothing is offered before the bench asks
    initial begin
        acc_valid = 1'b0;
        acc_x = 16'sh0000;
        acc_y = 16'sh0000;
        acc_z = 16'sh0000;
    end

    // raw reading offered
    // ready is first taken at the falling edge, retries take it just after the rising edge;
    // as ready is a level of the state, only the first try avoids racing the state update
    task automatic offer(input logic signed [15:0] x, input logic signed
        [15:0] y, input logic signed [15:0] z, output logic ok);
        logic rdy;
        int n;
        @(negedge sys_clk);
        ok = 1'b0;
        acc_x = x;
        acc_y = y;
        acc_z = z;
        acc_valid = 1'b1;
        for (n = 0; n < 200 && ok !== 1'b1; n++) begin
            rdy = acc_ready;
            @(posedge sys_clk);
            if (rdy === 1'b1) begin
                ok = 1'b1;
            end
        end
        // released lines show the inverse so stale data cannot pass
        @(negedge sys_clk);
        acc_valid = 1'b0;
        acc_x = ~x;
        acc_y = ~y;
        acc_z = ~z;
    endtask
endmodule // grac_acc_src
`default_nettype wire

// ===== sim/testbench.sv
// testbench: directed scenarios for the gravity rotation angle block.
// assumes grac_pkg compiled first; angle lsb is 180/32768 degree.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic sys_clk;
    logic rst_n;
    logic cfg_euler;
    logic signed [15:0] acc_x, acc_y, acc_z;
    logic acc_valid, acc_ready;
    logic signed [15:0] ang_pitch, ang_roll;
    logic ang_valid, ang_is_euler, flag_rollover;
    logic flag_pitch_lock, flag_roll_lock;
    int failures;
    int n_tests;
    int m;

    ////////////////////////////////////////////////////////////////////////
    grac_rotation grac_rotation_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
        .acc_valid(acc_valid), .acc_ready(acc_ready),
        .cfg_euler(cfg_euler), .ang_pitch(ang_pitch), .ang_roll(ang_roll),
        .ang_valid(ang_valid), .ang_is_euler(ang_is_euler),
        .flag_rollover(flag_rollover), .flag_pitch_lock(flag_pitch_lock),
        .flag_roll_lock(flag_roll_lock));
    grac_acc_src grac_acc_src_i (.sys_clk(sys_clk), .acc_ready(acc_ready),
        .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z),
        .acc_valid(acc_valid));

    ////////////////////////////////////////////////////////////////////////
    // free-running 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // an unknown result counts as a mismatch, never as a match
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    // engine error is a few lsb, so angles compare within a window
    function automatic logic near(input logic signed [15:0] a,
        input logic signed [15:0] e);
        logic signed [15:0] d;
        d = a - e;
        if ((^a) === 1'bx) begin
            return 1'b0;
        end
        return (d <= 16) && (d >= -16);
    endfunction

    // one sample through; flags are {rollover, pitch lock, roll lock}
    task automatic run(input logic signed [15:0] ax, input logic signed
        [15:0] ay, input logic signed [15:0] az, input logic eul,
        input logic signed [15:0] ep, input logic signed [15:0] er,
        input logic [2:0] ef, input logic [2:0] fm);
        logic ok;
        int n;
        @(negedge sys_clk);
        cfg_euler = eul;
        grac_acc_src_i.offer(ax, ay, az, ok);
        // a mode change while busy must not leak into this result
        cfg_euler = ~eul;
        chk(ok, "sample not taken");
        for (n = 1; n < 100; n++) begin
            @(posedge sys_clk);
            #1;
            if (ang_valid === 1'b1) begin
                break;
            end
            chk(acc_ready === 1'b0, "ready while busy");
        end
        chk(n >= 3 && n <= 80, "result latency");
        // a refused sample or a missing result ends the run here
        if (ok !== 1'b1 || n >= 100) begin
            final_report();
        end
        chk(near(ang_pitch, ep), "pitch value");
        chk(near(ang_roll, er), "roll value");
        chk(ang_is_euler === eul, "mode of result");
        chk((({flag_rollover, flag_pitch_lock, flag_roll_lock} ^ ef) & fm)
            === 3'b000, "status flags");
        chk(acc_ready === 1'b1, "ready after result");
        @(posedge sys_clk);
        #1;
        chk(ang_valid === 1'b0, "valid not a pulse");
        chk(near(ang_roll, er), "roll does not stand");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // level unit, reading negated to gravity
    task automatic t_level();
        for (m = 0; m < 2; m++) begin
            run(16'sh0000, 16'sh0000, -16'sd16384, m[0], 16'sh0000,
                16'sh0000, 3'b000, 3'b111);
        end
    endtask

    task automatic t_signs();
        run(16'sd10000, 16'sh0000, -16'sd10000, 1'b0, 16'sh2000, 16'sh0000,
            3'b000, 3'b111);
        run(-16'sd10000, 16'sh0000, -16'sd10000, 1'b0, 16'she000,
            16'sh0000, 3'b000, 3'b111);
        run(16'sh0000, -16'sd10000, -16'sd10000, 1'b0, 16'sh0000,
            16'sh2000, 3'b000, 3'b111);
    endtask

    task automatic t_rollover();
        run(16'sh0000, -16'sd10000, -16'sd200, 1'b0, 16'sh0000, 16'sh3f2f,
            3'b000, 3'b111);
        run(16'sh0000, -16'sd10000, 16'sd200, 1'b1, 16'sh0000, 16'sh40d1,
            3'b100, 3'b111);
        run(16'sd10000, 16'sh0000, 16'sd10000, 1'b0, 16'sh6000, 16'sh8000,
            3'b100, 3'b111);
        run(16'sd10000, 16'sh0000, 16'sd10000, 1'b1, 16'sh2000, 16'sh8000,
            3'b100, 3'b111);
    endtask

    // reset in mid-computation drops the sample and returns to idle
    task automatic t_reset();
        logic ok;
        @(negedge sys_clk);
        grac_acc_src_i.offer(16'sd10000, 16'sh0000, -16'sd10000, ok);
        chk(ok, "sample not taken");
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk({ang_pitch, ang_roll} === 32'h0000_0000, "angles after reset");
        chk(ang_valid === 1'b0 && acc_ready === 1'b1, "idle after reset");
        rst_n = 1'b1;
        run(16'sh0000, 16'sh0000, -16'sd16384, 1'b1, 16'sh0000,
            16'sh0000, 3'b000, 3'b111);
    endtask

    task automatic t_euler();
        run(16'sd10000, -16'sd6000, -16'sd8000, 1'b0, 16'sh2482, 16'sh1a38,
            3'b000, 3'b111);
        run(16'sd10000, -16'sd6000, -16'sd8000, 1'b1, 16'sh2000, 16'sh1a38,
            3'b000, 3'b111);
    endtask

    task automatic t_lock();
        for (m = 0; m < 2; m++) begin
            run(16'sh8000, 16'sh0000, 16'sh0000, m[0], 16'shc000, 16'sh0000,
                3'b001, 3'b011);
            run(16'sh0000, -16'sd16384, 16'sh0000, m[0], 16'sh0000,
                16'sh4000, {1'b0, ~m[0], 1'b0}, 3'b011);
            run(16'sh0000, 16'sh0000, 16'sh0000, m[0], 16'sh0000, 16'sh0000,
                3'b011, 3'b011);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // hang guard: counts as a mismatch and ends the run
    initial begin
        #500000;
        failures++;
        $display("BAD %0t run did not finish", $time);
        final_report();
    end

    // main sequence: reset for 4 cycles, then every scenario
    initial begin
        failures = 0;
        n_tests = 0;
        rst_n = 1'b0;
        cfg_euler = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk({ang_pitch, ang_roll} === 32'h0000_0000, "angles in reset");
        chk({ang_valid, ang_is_euler, flag_rollover, flag_pitch_lock,
            flag_roll_lock} === 5'h00, "flags in reset");
        chk(acc_ready === 1'b1, "ready in reset");
        @(negedge sys_clk);
        rst_n = 1'b1;
        t_level();
        t_signs();
        t_rollover();
        t_reset();
        t_euler();
        t_lock();
        final_report();
    end
endmodule // testbench
`default_nettype wire
